// ===== src/sttmr_pkg.sv
// package: register map, field positions and timing constants of the timers
`default_nettype none
package sttmr_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_TIMER_B_COUNT_LOW = 16'h00ac;
    localparam logic [15:0] IDX_TIMER_B_COUNT_HIGH = 16'h00ad;
    localparam logic [15:0] IDX_TIMER_A_COUNT_LOW = 16'h00ae;
    localparam logic [15:0] IDX_TIMER_A_COUNT_HIGH = 16'h00af;
    localparam logic [15:0] IDX_DUAL_TIMER_CONTROL_STATUS = 16'h00cf;
    localparam logic [15:0] IDX_LONG_TIMER_COUNT_TOP = 16'ha063;
    localparam logic [15:0] IDX_LONG_TIMER_CONTROL_STATUS = 16'ha068;
    localparam logic [15:0] IDX_LONG_TIMER_COUNT_LOW = 16'ha069;
    localparam logic [15:0] IDX_LONG_TIMER_COUNT_MID = 16'ha06a;
    // dual control/status field positions
    localparam int DUAL_B_FLAG = 7;
    localparam int DUAL_B_MODE = 6;
    localparam int DUAL_B_RUN = 5;
    localparam int DUAL_B_IEN = 4;
    localparam int DUAL_A_FLAG = 3;
    localparam int DUAL_A_MODE = 2;
    localparam int DUAL_A_RUN = 1;
    localparam int DUAL_A_IEN = 0;
    // long timer control/status field positions
    localparam int LONG_FLAG = 7;
    localparam int LONG_SEL_HI = 6;
    localparam int LONG_SEL_LO = 5;
    localparam int LONG_MODE = 4;
    localparam int LONG_RUN = 3;
    localparam int LONG_IEN = 0;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT16 = 16'h0000;
    localparam logic [23:0] RST_COUNT24 = 24'h000000;
    // oscillator rates and the divider counts derived from the core clock
    localparam int CORE_CLK_HZ = 125000000;
    localparam int FAST_OSC_HZ = 16000000;
    localparam int SLOW_OSC_HZ = 128000;
    localparam int FAST_DIV_CYCLES = CORE_CLK_HZ / FAST_OSC_HZ;
    localparam int SLOW_DIV_CYCLES = CORE_CLK_HZ / SLOW_OSC_HZ;
endpackage : sttmr_pkg
`default_nettype wire

// ===== src/sttmr_top.sv
// two 16-bit system timers and one 24-bit timer behind an ahb-lite slave
//
// Function
// - two 16-bit timers on system clock, reload/free-run
// - 16-bit overflow sets flag, software clears
// - mode bit one reload, zero free-run
// - run bit gates counting, clear holds count
// - interrupt requested only when enable is one
// - count write: reload register or live counter
// - count reads return live counter, no snapshot
// - 16-bit count as low/high bytes, reset zero
// - third timer, 24-bit, reload or free-run
// - select codes 0x pick fast, 1x slow
// - long timer counts through stop and sleep
// - long timer overflow serves as wake event
// - long timer mode: one reload, zero free-run
// - long timer counts only while run set
// - long overflow flag cleared only by zero
// - long interrupt only while enable is one
// - long count write: reload or live counter
// - long count as low/mid/top bytes, reset zero
//
// Register access over AHB-Lite was chosen for this implementation.
`default_nettype none
module sttmr_top
    import sttmr_pkg::*;
#(
    parameter int FAST_DIV = FAST_DIV_CYCLES,
    parameter int SLOW_DIV = SLOW_DIV_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic system_clock_stop_i,
    input wire logic fast_osc_on_i,
    input wire logic slow_osc_on_i,
    output logic timer_a_irq_o,
    output logic timer_b_irq_o,
    output logic long_timer_irq_o,
    output logic long_timer_wake_o
);

    // one increment step; at the top value loads the reload value or zero
    function automatic logic [23:0] step_next(
        input logic [23:0] cnt,
        input logic [23:0] rld,
        input logic [23:0] top,
        input logic mode
    );
        if (cnt == top) begin
            step_next = mode ? rld : 24'h000000;
        end else begin
            step_next = cnt + 24'h000001;
        end
    endfunction : step_next

    // a zero written to a flag clears it, a hardware set in the same cycle wins
    function automatic logic flag_next(
        input logic flag,
        input logic set,
        input logic wr,
        input logic wbit
    );
        flag_next = set | (flag & ~(wr & ~wbit));
    endfunction : flag_next

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    logic wr_pend_reg;
    logic [15:0] widx_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_value;

    wire take = hsel_i & htrans_i[1] & hready_i;
    wire mapped_hi = (haddr_i[31:18] == 14'h0000) & (haddr_i[1:0] == 2'b00);
    wire [15:0] aidx = haddr_i[17:2];
    wire [7:0] wbyte = hwdata_i[7:0];

    wire wr_b_lo = wr_pend_reg & (widx_reg == IDX_TIMER_B_COUNT_LOW);
    wire wr_b_hi = wr_pend_reg & (widx_reg == IDX_TIMER_B_COUNT_HIGH);
    wire wr_a_lo = wr_pend_reg & (widx_reg == IDX_TIMER_A_COUNT_LOW);
    wire wr_a_hi = wr_pend_reg & (widx_reg == IDX_TIMER_A_COUNT_HIGH);
    wire wr_dual = wr_pend_reg & (widx_reg == IDX_DUAL_TIMER_CONTROL_STATUS);
    wire wr_l_top = wr_pend_reg & (widx_reg == IDX_LONG_TIMER_COUNT_TOP);
    wire wr_lctl = wr_pend_reg & (widx_reg == IDX_LONG_TIMER_CONTROL_STATUS);
    wire wr_l_lo = wr_pend_reg & (widx_reg == IDX_LONG_TIMER_COUNT_LOW);
    wire wr_l_mid = wr_pend_reg & (widx_reg == IDX_LONG_TIMER_COUNT_MID);

    // a write lands at the end of its data phase, when hwdata stands
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wr_pend_reg <= 1'b0;
            widx_reg <= 16'h0000;
            hrdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= take & hwrite_i & mapped_hi;
            widx_reg <= aidx;
            // read latched at the address phase: a read straight after a
            // write to the same register returns the old value
            if (take & ~hwrite_i) begin
                hrdata_reg <= mapped_hi ? rd_value : 32'h00000000;
            end
        end
    end

    // zero wait states, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // control/status registers

    logic [7:0] dual_reg;
    logic long_flag_reg;
    logic [1:0] long_sel_reg;
    logic long_mode_reg;
    logic long_run_reg;
    logic long_ien_reg;

    logic [15:0] cnt_a_reg;
    logic [15:0] cnt_b_reg;
    logic [15:0] rld_a_reg;
    logic [15:0] rld_b_reg;
    logic [23:0] cnt_l_reg;
    logic [23:0] rld_l_reg;
    logic long_ovf_reg;

    wire mode_a = dual_reg[DUAL_A_MODE];
    wire mode_b = dual_reg[DUAL_B_MODE];
    // stop/sleep gates the system clock, so the 16-bit timers freeze
    wire cnt_en_a = dual_reg[DUAL_A_RUN] & ~system_clock_stop_i;
    wire cnt_en_b = dual_reg[DUAL_B_RUN] & ~system_clock_stop_i;
    wire ovf_a = cnt_en_a & (cnt_a_reg == 16'hffff);
    wire ovf_b = cnt_en_b & (cnt_b_reg == 16'hffff);

    wire [7:0] long_ctl = {long_flag_reg, long_sel_reg, long_mode_reg,
        long_run_reg, 2'b00, long_ien_reg};

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            dual_reg <= RST_BYTE;
        end else begin
            if (wr_dual) begin
                dual_reg <= wbyte;
            end
            dual_reg[DUAL_A_FLAG] <= flag_next(dual_reg[DUAL_A_FLAG], ovf_a,
                wr_dual, wbyte[DUAL_A_FLAG]);
            dual_reg[DUAL_B_FLAG] <= flag_next(dual_reg[DUAL_B_FLAG], ovf_b,
                wr_dual, wbyte[DUAL_B_FLAG]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 16-bit timers

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_a_reg <= RST_COUNT16;
            rld_a_reg <= RST_COUNT16;
            cnt_b_reg <= RST_COUNT16;
            rld_b_reg <= RST_COUNT16;
        end else begin
            if (cnt_en_a) begin
                cnt_a_reg <= 16'(step_next({8'h00, cnt_a_reg},
                    {8'h00, rld_a_reg}, 24'h00ffff, mode_a));
            end
            if (cnt_en_b) begin
                cnt_b_reg <= 16'(step_next({8'h00, cnt_b_reg},
                    {8'h00, rld_b_reg}, 24'h00ffff, mode_b));
            end
            // a free-run count write overrides the increment of the same cycle in the byte it writes
            if (wr_a_lo & mode_a) rld_a_reg[7:0] <= wbyte;
            if (wr_a_hi & mode_a) rld_a_reg[15:8] <= wbyte;
            if (wr_a_lo & ~mode_a) cnt_a_reg[7:0] <= wbyte;
            if (wr_a_hi & ~mode_a) cnt_a_reg[15:8] <= wbyte;
            if (wr_b_lo & mode_b) rld_b_reg[7:0] <= wbyte;
            if (wr_b_hi & mode_b) rld_b_reg[15:8] <= wbyte;
            if (wr_b_lo & ~mode_b) cnt_b_reg[7:0] <= wbyte;
            if (wr_b_hi & ~mode_b) cnt_b_reg[15:8] <= wbyte;
        end
    end

    assign timer_a_irq_o = dual_reg[DUAL_A_FLAG] & dual_reg[DUAL_A_IEN];
    assign timer_b_irq_o = dual_reg[DUAL_B_FLAG] & dual_reg[DUAL_B_IEN];

    ////////////////////////////////////////////////////////////////////////
    // oscillator ticks and 24-bit timer

    // oscillators are modelled as enables from dividers of the core clock
    logic [15:0] fdiv_reg;
    logic [15:0] sdiv_reg;
    wire fast_tick = fast_osc_on_i & (fdiv_reg == 16'(FAST_DIV - 1));
    wire slow_tick = slow_osc_on_i & (sdiv_reg == 16'(SLOW_DIV - 1));
    wire long_tick = long_sel_reg[1] ? slow_tick : fast_tick;
    // no stop/sleep term: the long timer keeps running in low power
    wire cnt_en_l = long_run_reg & long_tick;
    wire ovf_l = cnt_en_l & (cnt_l_reg == 24'hffffff);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            fdiv_reg <= 16'h0000;
            sdiv_reg <= 16'h0000;
        end else begin
            fdiv_reg <= (fast_tick | ~fast_osc_on_i) ? 16'h0000 :
                fdiv_reg + 16'h0001;
            sdiv_reg <= (slow_tick | ~slow_osc_on_i) ? 16'h0000 :
                sdiv_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            long_flag_reg <= 1'b0;
            long_sel_reg <= 2'b00;
            long_mode_reg <= 1'b0;
            long_run_reg <= 1'b0;
            long_ien_reg <= 1'b0;
            long_ovf_reg <= 1'b0;
        end else begin
            if (wr_lctl) begin
                long_sel_reg <= wbyte[LONG_SEL_HI:LONG_SEL_LO];
                long_mode_reg <= wbyte[LONG_MODE];
                long_run_reg <= wbyte[LONG_RUN];
                long_ien_reg <= wbyte[LONG_IEN];
            end
            long_flag_reg <= flag_next(long_flag_reg, ovf_l, wr_lctl,
                wbyte[LONG_FLAG]);
            long_ovf_reg <= ovf_l;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_l_reg <= RST_COUNT24;
            rld_l_reg <= RST_COUNT24;
        end else begin
            if (cnt_en_l) begin
                cnt_l_reg <= step_next(cnt_l_reg, rld_l_reg, 24'hffffff,
                    long_mode_reg);
            end
            if (wr_l_lo & long_mode_reg) rld_l_reg[7:0] <= wbyte;
            if (wr_l_mid & long_mode_reg) rld_l_reg[15:8] <= wbyte;
            if (wr_l_top & long_mode_reg) rld_l_reg[23:16] <= wbyte;
            if (wr_l_lo & ~long_mode_reg) cnt_l_reg[7:0] <= wbyte;
            if (wr_l_mid & ~long_mode_reg) cnt_l_reg[15:8] <= wbyte;
            if (wr_l_top & ~long_mode_reg) cnt_l_reg[23:16] <= wbyte;
        end
    end

    assign long_timer_irq_o = long_flag_reg & long_ien_reg;
    assign long_timer_wake_o = long_ovf_reg;

    ////////////////////////////////////////////////////////////////////////
    // read mux: live counters, never a snapshot

    always_comb begin
        rd_value = 32'h00000000;
        if (aidx == IDX_TIMER_B_COUNT_LOW) begin
            rd_value[7:0] = cnt_b_reg[7:0];
        end else if (aidx == IDX_TIMER_B_COUNT_HIGH) begin
            rd_value[7:0] = cnt_b_reg[15:8];
        end else if (aidx == IDX_TIMER_A_COUNT_LOW) begin
            rd_value[7:0] = cnt_a_reg[7:0];
        end else if (aidx == IDX_TIMER_A_COUNT_HIGH) begin
            rd_value[7:0] = cnt_a_reg[15:8];
        end else if (aidx == IDX_DUAL_TIMER_CONTROL_STATUS) begin
            rd_value[7:0] = dual_reg;
        end else if (aidx == IDX_LONG_TIMER_COUNT_TOP) begin
            rd_value[7:0] = cnt_l_reg[23:16];
        end else if (aidx == IDX_LONG_TIMER_CONTROL_STATUS) begin
            rd_value[7:0] = long_ctl;
        end else if (aidx == IDX_LONG_TIMER_COUNT_LOW) begin
            rd_value[7:0] = cnt_l_reg[7:0];
        end else if (aidx == IDX_LONG_TIMER_COUNT_MID) begin
            rd_value[7:0] = cnt_l_reg[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    wire no_wr_a = ~wr_a_lo & ~wr_a_hi;
    wire no_wr_l = ~wr_l_lo & ~wr_l_mid & ~wr_l_top;
    wire no_wr_b = ~wr_b_lo & ~wr_b_hi;

    sequence s_read_long_ctl;
        take & ~hwrite_i & mapped_hi & (aidx == IDX_LONG_TIMER_CONTROL_STATUS);
    endsequence

    sequence s_long_overflow;
        ovf_l & long_run_reg;
    endsequence

    sequence s_wake_pulse;
        long_flag_reg & long_timer_wake_o;
    endsequence

    a_flag_a_sticky: assert property (
        dual_reg[DUAL_A_FLAG] & ~wr_dual |=> dual_reg[DUAL_A_FLAG])
        else $error("timer a flag dropped without a write");
    a_ovf_a_flag: assert property (ovf_a |=> dual_reg[DUAL_A_FLAG])
        else $error("timer a overflow did not set flag");
    a_run_hold_a: assert property (
        ~dual_reg[DUAL_A_RUN] & no_wr_a |=> $stable(cnt_a_reg))
        else $error("stopped timer a changed count");
    a_free_wrap_a: assert property (
        ovf_a & ~mode_a & no_wr_a |=> cnt_a_reg == 16'h0000)
        else $error("free-run timer a did not wrap to zero");
    a_reload_a_load: assert property (
        ovf_a & mode_a & no_wr_a |=> cnt_a_reg == $past(rld_a_reg))
        else $error("reload timer a did not load reload value");
    a_irq_b_gate: assert property (
        ~dual_reg[DUAL_B_IEN] |-> ~timer_b_irq_o)
        else $error("timer b irq raised while disabled");
    a_long_run_hold: assert property (
        ~long_run_reg & no_wr_l |=> $stable(cnt_l_reg))
        else $error("stopped long timer changed count");
    a_long_ovf_wake: assert property (
        s_long_overflow |=> s_wake_pulse)
        else $error("long overflow did not flag and wake");
    a_wake_no_ovf: assert property (
        ~ovf_l |=> ~long_timer_wake_o)
        else $error("wake pulse without long overflow");
    a_long_ctl_zero: assert property (
        s_read_long_ctl |=> hrdata_o[2:1] == 2'b00)
        else $error("long control bits 2:1 not zero");
    a_write_a_free: assert property (
        wr_a_lo & ~mode_a |=> cnt_a_reg[7:0] == $past(wbyte))
        else $error("free-run write did not reach counter");
    a_flag_b_sticky: assert property (
        dual_reg[DUAL_B_FLAG] & ~wr_dual |=> dual_reg[DUAL_B_FLAG])
        else $error("timer b flag dropped without a write");
    a_ovf_b_flag: assert property (ovf_b |=> dual_reg[DUAL_B_FLAG])
        else $error("timer b overflow did not set flag");
    a_run_hold_b: assert property (
        ~dual_reg[DUAL_B_RUN] & no_wr_b |=> $stable(cnt_b_reg))
        else $error("stopped timer b changed count");
    a_stop_freeze_a: assert property (
        system_clock_stop_i & no_wr_a |=> $stable(cnt_a_reg))
        else $error("timer a counted with system clock stopped");
    a_reload_b_load: assert property (
        ovf_b & mode_b & no_wr_b |=> cnt_b_reg == $past(rld_b_reg))
        else $error("reload timer b did not load reload value");
    a_write_b_reload: assert property (
        wr_b_hi & mode_b |=> rld_b_reg[15:8] == $past(wbyte))
        else $error("reload-mode write did not reach reload register");
    a_irq_a_gate: assert property (
        ~dual_reg[DUAL_A_IEN] |-> ~timer_a_irq_o)
        else $error("timer a irq raised while disabled");
    a_long_flag_sticky: assert property (
        long_flag_reg & ~wr_lctl |=> long_flag_reg)
        else $error("long flag dropped without a write");
    a_long_free_wrap: assert property (
        ovf_l & ~long_mode_reg & no_wr_l |=> cnt_l_reg == 24'h000000)
        else $error("free-run long timer did not wrap to zero");
    a_long_reload: assert property (
        ovf_l & long_mode_reg & no_wr_l |=> cnt_l_reg == $past(rld_l_reg))
        else $error("reload long timer did not load reload value");
    a_long_irq_gate: assert property (
        ~long_ien_reg |-> ~long_timer_irq_o)
        else $error("long irq raised while disabled");

endmodule : sttmr_top
`default_nettype wire

// ===== bench/tb_system_timers_16_24_bit.sv
// self-checking testbench of the system timers block
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
$display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module tb_system_timers_16_24_bit import sttmr_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] idx;
        logic [7:0] wd;
        logic [7:0] ex;
    } sttmr_row_t;
    localparam logic [15:0] AL = IDX_TIMER_A_COUNT_LOW;
    localparam logic [15:0] AH = IDX_TIMER_A_COUNT_HIGH;
    localparam logic [15:0] BL = IDX_TIMER_B_COUNT_LOW;
    localparam logic [15:0] BH = IDX_TIMER_B_COUNT_HIGH;
    localparam logic [15:0] DC = IDX_DUAL_TIMER_CONTROL_STATUS;
    localparam logic [15:0] LC = IDX_LONG_TIMER_CONTROL_STATUS;
    localparam logic [15:0] LL = IDX_LONG_TIMER_COUNT_LOW;
    localparam logic [15:0] LM = IDX_LONG_TIMER_COUNT_MID;
    localparam logic [15:0] LT = IDX_LONG_TIMER_COUNT_TOP;
    logic clk, rstn, hsel, hwrite, hrdy, hresp, stop, fon, son;
    logic ia, ib, il, wk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] v;
    int num_errors, cmp_count, k;
    // write a row's data, then read back; flags written as one stay clear
    sttmr_row_t rows [11] = '{
        '{DC, 8'hcc, 8'h44}, '{AL, 8'h5a, 8'h00}, '{LC, 8'h97, 8'h11},
        '{LL, 8'h5a, 8'h00}, '{DC, 8'h00, 8'h00}, '{AH, 8'ha5, 8'ha5},
        '{BL, 8'h3c, 8'h3c}, '{LC, 8'h00, 8'h00}, '{LT, 8'h7e, 8'h7e},
        '{LM, 8'h81, 8'h81}, '{16'h0100, 8'hff, 8'h00}};

    // slow source shortened so the 24-bit overflow stays within reach
    sttmr_top #(.SLOW_DIV(4)) uut (.core_clk_i(clk), .rstn_i(rstn),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp),
        .hrdata_o(hrdata), .system_clock_stop_i(stop), .fast_osc_on_i(fon),
        .slow_osc_on_i(son), .timer_a_irq_o(ia), .timer_b_irq_o(ib),
        .long_timer_irq_o(il), .long_timer_wake_o(wk));

    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic wrdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 64);
        if (hrdy !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t bus ready timeout", $time);
            give_verdict();
        end
    endtask : wrdy

    task automatic bus(input logic [15:0] idx, input logic w,
                       input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {14'h0000, idx, 2'b00};
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        wrdy();
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus

    task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00);
        `CHK(rd, {24'h000000, e})
    endtask : rchk

    // polls a status bit; a bound that runs out ends the run
    task automatic poll(input logic [15:0] idx, input int b);
        int n;
        n = 0;
        do begin
            bus(idx, 1'b0, 8'h00);
            n++;
        end while (rd[b] !== 1'b1 && n < 100);
        if (rd[b] !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t status poll timeout", $time);
            give_verdict();
        end
    endtask : poll

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, stop} = '0;
        hsize = 3'b010;
        {fon, son} = 2'b11;
        num_errors = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rchk(rows[i].idx, 8'h00);
        end
        `CHK({ia, ib, il, wk}, 4'h0)
        for (int i = 0; i < 11; i++) begin
            bus(rows[i].idx, 1'b1, rows[i].wd);
            rchk(rows[i].idx, rows[i].ex);
        end
        // timer a free-run overflow with interrupt masked
        bus(AH, 1'b1, 8'hff);
        bus(AL, 1'b1, 8'hf0);
        bus(DC, 1'b1, 8'h02);
        poll(DC, DUAL_A_FLAG);
        `CHK(ia, 1'b0)
        bus(DC, 1'b1, 8'h08);
        rchk(DC, 8'h08);
        rchk(AH, 8'h00);
        bus(AL, 1'b0, 8'h00);
        v = rd[7:0];
        repeat (10) @(posedge clk);
        rchk(AL, v);
        bus(DC, 1'b1, 8'h09);
        @(negedge clk);
        `CHK(ia, 1'b1)
        bus(DC, 1'b1, 8'h01);
        @(negedge clk);
        `CHK(ia, 1'b0)
        // timer b reload: count writes go to the reload register
        bus(BH, 1'b1, 8'hff);
        bus(BL, 1'b1, 8'hf0);
        bus(DC, 1'b1, 8'h40);
        bus(BH, 1'b1, 8'h12);
        rchk(BH, 8'hff);
        bus(DC, 1'b1, 8'h60);
        poll(DC, DUAL_B_FLAG);
        bus(DC, 1'b1, 8'hc0);
        rchk(BH, 8'h12);
        `CHK(ib, 1'b0)
        bus(DC, 1'b1, 8'h90);
        @(negedge clk);
        `CHK(ib, 1'b1)
        bus(DC, 1'b1, 8'h00);
        // stop mode freezes timer a, long timer keeps its own source
        @(posedge clk);
        stop <= 1'b1;
        son <= 1'b0;
        bus(DC, 1'b1, 8'h02);
        bus(AL, 1'b0, 8'h00);
        v = rd[7:0];
        repeat (10) @(posedge clk);
        rchk(AL, v);
        for (int c = 0; c < 4; c++) begin
            bus(LC, 1'b1, {1'b0, 2'(c), 5'b01000});
            bus(LL, 1'b0, 8'h00);
            v = rd[7:0];
            repeat (40) @(posedge clk);
            bus(LL, 1'b0, 8'h00);
            `CHK(rd[7:0] !== v, c < 2)
        end
        bus(LC, 1'b1, 8'h00);
        bus(LL, 1'b0, 8'h00);
        v = rd[7:0];
        repeat (40) @(posedge clk);
        rchk(LL, v);
        bus(DC, 1'b1, 8'h00);
        stop <= 1'b0;
        son <= 1'b1;
        // long timer overflow: wake pulse, flag, masked interrupt
        bus(LT, 1'b1, 8'hff);
        bus(LM, 1'b1, 8'hff);
        bus(LL, 1'b1, 8'hf0);
        bus(LC, 1'b1, 8'h48);
        k = 0;
        while (wk !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        `CHK(wk, 1'b1)
        @(negedge clk);
        `CHK({wk, il}, 2'b00)
        rchk(LC, 8'hc8);
        bus(LC, 1'b1, 8'hc1);
        @(negedge clk);
        `CHK(il, 1'b1)
        rchk(LT, 8'h00);
        bus(LC, 1'b1, 8'h01);
        @(negedge clk);
        `CHK(il, 1'b0)
        // long timer reload: count writes go to the reload register
        bus(LT, 1'b1, 8'hff);
        bus(LM, 1'b1, 8'hff);
        bus(LL, 1'b1, 8'hf8);
        bus(LC, 1'b1, 8'h10);
        bus(LT, 1'b1, 8'h34);
        bus(LL, 1'b1, 8'h56);
        rchk(LT, 8'hff);
        bus(LC, 1'b1, 8'h58);
        poll(LC, LONG_FLAG);
        bus(LC, 1'b1, 8'h10);
        rchk(LT, 8'h34);
        // second reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rchk(BH, 8'h00);
        rchk(LC, 8'h00);
        rchk(LT, 8'h00);
        give_verdict();
    end
endmodule : tb_system_timers_16_24_bit
`default_nettype wire
